//--- logic/rsm_top.sv
// reset sequencer: sources, pin drive, delay phases, vector fetch, cause flags
// assumes Avalon-MM master on clk; comparators and reset pin asynchronous
//
// Overview of operation
// - supply droop holds the device in reset continuously
// - rising threshold while droop reset active, falling threshold otherwise
// - droop reset drives the reset pin low
// - droop reference level picked by a static option input
// - droop flag set by hardware, cleared by writing zero
// - every source drives the pin low through the delay phase
// - program counter loaded from vector at FFFE-FFFF
// - phases: source delay, 4096 cycle wait, vector fetch
// - vector fetch takes exactly two cycles
// - external pulse caught without the clock
// - after external pulse the pin is driven low at least the minimum time
// - watchdog underflow drives pin low at least minimum, then sequence
// - pin is open drain, driven only low
// - oscillator kept running during reset
// - clock source chosen by static option input
// - clock supervisor enabled by static option input
// - short supply glitches filtered out
// - dog flag set on watchdog reset, cleared by zero write or droop
// - droop flag survives later external and watchdog resets
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rsm_top (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe,
	input  wire logic        above_rise,
	input  wire logic        above_fall,
	input  wire logic        wdg_underflow,
	input  wire logic        safe_osc_active,
	input  wire logic [1:0]  droop_level_opt,
	input  wire logic [2:0]  clk_src_opt,
	input  wire logic        supervisor_opt,
	output logic [1:0]       droop_level,
	output logic [2:0]       clock_source_selector,
	output logic             clock_supervisor_en,
	output logic             osc_keep_run,
	output logic             core_reset_n,
	output logic             vec_rd,
	output logic [15:0]      vec_addr,
	input  wire logic [7:0]  vec_data,
	output logic [15:0]      pc,
	output logic             pc_load
);
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		rsm_pkg::rsm_state_t       st;
		logic [rsm_pkg::CNT_W-1:0] cnt;
		logic                      droop_flag;
		logic                      dog_flag;
		logic                      cssd;
		logic                      cssie;
		logic                      wreq;
		logic [31:0]               rdata;
		logic [15:0]               pc;
		logic                      pc_load;
		logic                      vec_rd;
		logic [15:0]               vec_addr;
		logic                      core_rst_n;
		logic                      pin_oe;
		logic                      pin_val;
		logic                      guard;
		logic                      osc;
		logic [1:0]                lvl_s1;
		logic [2:0]                src_s1;
		logic [1:0]                lvl;
		logic [2:0]                src;
		logic                      sup;
		logic [1:0]                opt_s1;
		logic [1:0]                opt_s2;
	} rsm_regs_t;

	localparam int OUT_LAST = rsm_pkg::OUT_CYC - 1;
	localparam int STAB_LAST = rsm_pkg::STAB_CYC - 1;
	localparam int ONE = 1;
	localparam logic [rsm_pkg::CNT_W-1:0] OUT_END = OUT_LAST[rsm_pkg::CNT_W-1:0];
	localparam logic [rsm_pkg::CNT_W-1:0] STAB_END = STAB_LAST[rsm_pkg::CNT_W-1:0];
	localparam logic [rsm_pkg::CNT_W-1:0] CNT_ONE = ONE[rsm_pkg::CNT_W-1:0];
	localparam logic [rsm_pkg::CNT_W-1:0] CNT_ZERO = '0;

	rsm_regs_t   r;
	rsm_regs_t   next_r;
	logic        droop_act;
	logic        ext_req;
	logic        any_src;
	logic        own_mask;
	logic        bus_req;
	logic        bus_done;
	logic        rd_cause;
	logic        wr_cause;
	logic        sup_s;
	logic        safe_s;
	logic [31:0] cause_word;
	logic [31:0] read_word;

	////////////////////////////////////////////////////////////////
	// mask stays up one cycle past release so the rising pin is not caught
	rsm_pin_catch u_catch (
		.clk       (clk),
		.resetn    (resetn),
		.pin_in    (rst_pin_in),
		.own_drive (own_mask),
		.ack       (r.pin_oe),
		.ext_req   (ext_req)
	);

	rsm_droop_filter u_droop (
		.clk        (clk),
		.resetn     (resetn),
		.above_rise (above_rise),
		.above_fall (above_fall),
		.droop_act  (droop_act)
	);

	////////////////////////////////////////////////////////////////
	// sources and bus decode
	assign any_src = droop_act | ext_req | wdg_underflow;
	assign own_mask = r.pin_oe | r.guard;
	assign bus_req = avs_read | avs_write;
	assign bus_done = bus_req & !r.wreq;
	assign rd_cause = bus_done & avs_read & (avs_address == rsm_pkg::CAUSE_OFS);
	assign wr_cause = bus_done & avs_write & avs_byteenable[0]
		& (avs_address == rsm_pkg::CAUSE_OFS);
	assign sup_s = r.opt_s2[1];
	assign safe_s = r.opt_s2[0];

	// read word for the addressed register
	always_comb begin
		cause_word = 32'h0000_0000;
		cause_word[rsm_pkg::DROOP_BIT] = r.droop_flag;
		cause_word[rsm_pkg::CSSIE_BIT] = r.cssie;
		cause_word[rsm_pkg::CSSD_BIT] = r.cssd;
		cause_word[rsm_pkg::DOG_BIT] = r.dog_flag;
		read_word = 32'h0000_0000;
		if (avs_address == rsm_pkg::CAUSE_OFS)
			read_word = cause_word;
		else if (avs_address == rsm_pkg::STATUS_OFS)
			read_word[4:0] = r.st;
	end

	////////////////////////////////////////////////////////////////
	// sequencer, flags, bus and option levels
	always_comb begin
		next_r = r;
		next_r.pc_load = 1'b0;
		next_r.vec_rd = 1'b0;
		next_r.pin_val = 1'b0;
		next_r.osc = 1'b1;
		next_r.guard = r.pin_oe;
		next_r.opt_s1 = {supervisor_opt, safe_osc_active};
		next_r.opt_s2 = r.opt_s1;
		next_r.lvl_s1 = droop_level_opt;
		next_r.lvl = r.lvl_s1;
		next_r.src_s1 = clk_src_opt;
		next_r.src = r.src_s1;
		next_r.sup = sup_s;

		unique case (r.st)
			rsm_pkg::RSM_RUN: begin
				if (any_src) begin
					next_r.st = rsm_pkg::RSM_DELAY;
					next_r.cnt = CNT_ZERO;
					next_r.pin_oe = 1'b1;
					next_r.core_rst_n = 1'b0;
				end
			end
			rsm_pkg::RSM_DELAY: begin
				next_r.pin_oe = 1'b1;
				next_r.core_rst_n = 1'b0;
				if (any_src)
					next_r.cnt = CNT_ZERO;
				else if (r.cnt == OUT_END) begin
					next_r.st = rsm_pkg::RSM_STAB;
					next_r.cnt = CNT_ZERO;
					next_r.pin_oe = 1'b0;
				end else
					next_r.cnt = r.cnt + CNT_ONE;
			end
			rsm_pkg::RSM_STAB: begin
				if (any_src) begin
					next_r.st = rsm_pkg::RSM_DELAY;
					next_r.cnt = CNT_ZERO;
					next_r.pin_oe = 1'b1;
				end else if (r.cnt == STAB_END) begin
					next_r.st = rsm_pkg::RSM_FHI;
					next_r.cnt = CNT_ZERO;
					next_r.vec_rd = 1'b1;
					next_r.vec_addr = rsm_pkg::VEC_HI;
				end else
					next_r.cnt = r.cnt + CNT_ONE;
			end
			rsm_pkg::RSM_FHI: begin
				if (any_src) begin
					next_r.st = rsm_pkg::RSM_DELAY;
					next_r.cnt = CNT_ZERO;
					next_r.pin_oe = 1'b1;
				end else begin
					next_r.st = rsm_pkg::RSM_FLO;
					next_r.pc[15:8] = vec_data;
					next_r.vec_rd = 1'b1;
					next_r.vec_addr = rsm_pkg::VEC_LO;
				end
			end
			rsm_pkg::RSM_FLO: begin
				if (any_src) begin
					next_r.st = rsm_pkg::RSM_DELAY;
					next_r.cnt = CNT_ZERO;
					next_r.pin_oe = 1'b1;
				end else begin
					next_r.st = rsm_pkg::RSM_RUN;
					next_r.pc[7:0] = vec_data;
					next_r.pc_load = 1'b1;
					next_r.core_rst_n = 1'b1;
				end
			end
			default: begin
				next_r.st = rsm_pkg::RSM_DELAY;
				next_r.cnt = CNT_ZERO;
				next_r.pin_oe = 1'b1;
				next_r.core_rst_n = 1'b0;
			end
		endcase

		// set wins over a clear in the same cycle
		if (droop_act)
			next_r.droop_flag = 1'b1;
		else if (wr_cause && !avs_writedata[rsm_pkg::DROOP_BIT])
			next_r.droop_flag = 1'b0;
		if (wdg_underflow)
			next_r.dog_flag = 1'b1;
		else if (droop_act)
			next_r.dog_flag = 1'b0;
		else if (wr_cause && !avs_writedata[rsm_pkg::DOG_BIT])
			next_r.dog_flag = 1'b0;
		if (wr_cause)
			next_r.cssie = avs_writedata[rsm_pkg::CSSIE_BIT];
		if (!sup_s)
			next_r.cssd = 1'b0;
		else if (safe_s)
			next_r.cssd = 1'b1;
		else if (rd_cause)
			next_r.cssd = 1'b0;

		// one wait state, then the answer stands for one cycle
		next_r.wreq = 1'b1;
		if (bus_req && r.wreq) begin
			next_r.wreq = 1'b0;
			next_r.rdata = read_word;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '{
				st:         rsm_pkg::RSM_DELAY,
				cnt:        CNT_ZERO,
				droop_flag: 1'b1,
				dog_flag:   1'b0,
				cssd:       1'b0,
				cssie:      1'b0,
				wreq:       1'b1,
				rdata:      32'h0000_0000,
				pc:         16'h0000,
				pc_load:    1'b0,
				vec_rd:     1'b0,
				vec_addr:   16'h0000,
				core_rst_n: 1'b0,
				pin_oe:     1'b1,
				pin_val:    1'b0,
				guard:      1'b1,
				osc:        1'b1,
				lvl_s1:     2'h0,
				src_s1:     3'h0,
				lvl:        2'h0,
				src:        3'h0,
				sup:        1'b0,
				opt_s1:     2'h0,
				opt_s2:     2'h0
			};
		end else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.wreq;
	assign rst_pin_out = r.pin_val;
	assign rst_pin_oe = r.pin_oe;
	assign droop_level = r.lvl;
	assign clock_source_selector = r.src;
	assign clock_supervisor_en = r.sup;
	assign osc_keep_run = r.osc;
	assign core_reset_n = r.core_rst_n;
	assign vec_rd = r.vec_rd;
	assign vec_addr = r.vec_addr;
	assign pc = r.pc;
	assign pc_load = r.pc_load;

	////////////////////////////////////////////////////////////////
	// checks
	property p_droop_hold;
		@(posedge clk) disable iff (!resetn)
		droop_act |=> (r.pin_oe && !r.core_rst_n);
	endproperty
	a_droop_hold: assert property (p_droop_hold)
		else $error("droop did not hold reset");

	property p_pin_low_delay;
		@(posedge clk) disable iff (!resetn)
		(r.st == rsm_pkg::RSM_DELAY) |-> r.pin_oe;
	endproperty
	a_pin_low_delay: assert property (p_pin_low_delay)
		else $error("pin released in delay phase");

	property p_min_out;
		@(posedge clk) disable iff (!resetn)
		$fell(r.pin_oe) |-> ($past(r.cnt) == OUT_END);
	endproperty
	a_min_out: assert property (p_min_out)
		else $error("pin released before minimum width");

	property p_stab_start;
		@(posedge clk) disable iff (!resetn)
		((r.st == rsm_pkg::RSM_STAB) && ($past(r.st) != rsm_pkg::RSM_STAB)) |-> (r.cnt == CNT_ZERO);
	endproperty
	a_stab_start: assert property (p_stab_start)
		else $error("wait count not restarted");

	property p_stab_end;
		@(posedge clk) disable iff (!resetn)
		((r.st == rsm_pkg::RSM_STAB) && (r.cnt == STAB_END) && !any_src) |=> (r.st == rsm_pkg::RSM_FHI);
	endproperty
	a_stab_end: assert property (p_stab_end)
		else $error("fetch not entered after wait");

	property p_fetch_hi;
		@(posedge clk) disable iff (!resetn)
		((r.st == rsm_pkg::RSM_FHI) && !any_src) |=> ((r.st == rsm_pkg::RSM_FLO) && r.vec_rd);
	endproperty
	a_fetch_hi: assert property (p_fetch_hi)
		else $error("second fetch cycle missing");

	property p_fetch_lo;
		@(posedge clk) disable iff (!resetn)
		((r.st == rsm_pkg::RSM_FLO) && !any_src) |=> (r.pc_load && r.core_rst_n && !r.vec_rd);
	endproperty
	a_fetch_lo: assert property (p_fetch_lo)
		else $error("vector not loaded after fetch");

	property p_droop_flag;
		@(posedge clk) disable iff (!resetn)
		droop_act |=> r.droop_flag;
	endproperty
	a_droop_flag: assert property (p_droop_flag)
		else $error("droop flag not set");

	property p_dog_flag;
		@(posedge clk) disable iff (!resetn)
		wdg_underflow |=> r.dog_flag;
	endproperty
	a_dog_flag: assert property (p_dog_flag)
		else $error("dog flag not set");

	property p_open_drain;
		@(posedge clk) disable iff (!resetn)
		r.pin_oe |-> !r.pin_val;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("pin driven high");
endmodule
`default_nettype wire

//--- logic/rsm_pkg.sv
// constants for the reset sequence manager
// assumes a 25 MHz clk and byte addresses on the register bus
package rsm_pkg;
	localparam int CLK_MHZ = 25;
	localparam int T_RSTL_OUT_NS = 20000;
	localparam int T_GLITCH_NS = 200;
	localparam int OUT_CYC = (T_RSTL_OUT_NS * CLK_MHZ + 999) / 1000;
	localparam int GLITCH_CYC = (T_GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int STAB_CYC = 4096;
	localparam int CNT_W = 13;
	localparam logic [15:0] VEC_HI = 16'hFFFE;
	localparam logic [15:0] VEC_LO = 16'hFFFF;
	localparam logic [3:0] CAUSE_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam int DROOP_BIT = 4;
	localparam int CSSIE_BIT = 2;
	localparam int CSSD_BIT = 1;
	localparam int DOG_BIT = 0;
	localparam logic [4:0] S_RUN = 5'h01;
	localparam logic [4:0] S_DELAY = 5'h02;
	localparam logic [4:0] S_STAB = 5'h04;
	localparam logic [4:0] S_FHI = 5'h08;
	localparam logic [4:0] S_FLO = 5'h10;
	typedef enum logic [4:0] {
		RSM_RUN   = S_RUN,
		RSM_DELAY = S_DELAY,
		RSM_STAB  = S_STAB,
		RSM_FHI   = S_FHI,
		RSM_FLO   = S_FLO
	} rsm_state_t;
endpackage

//--- logic/rsm_pin_catch.sv
// asynchronous catch of an external low pulse on the reset pin
// assumes own_drive comes from a flop on clk
`timescale 1ns/100ps
`default_nettype none
module rsm_pin_catch (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pin_in,
	input  wire logic own_drive,
	input  wire logic ack,
	output logic      ext_req
);
	logic set_n;
	logic caught;
	logic s1;
	logic s2;

	// own drive masked so the device does not retrigger itself
	assign set_n = pin_in | own_drive;

	// catches the pulse without any clock edge
	always_ff @(posedge clk or negedge resetn or negedge set_n) begin
		if (!resetn)
			caught <= 1'b0;
		else if (!set_n)
			caught <= 1'b1;
		else if (ack)
			caught <= 1'b0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
		end else begin
			s1 <= caught;
			s2 <= s1;
		end
	end

	assign ext_req = s2;
endmodule
`default_nettype wire

//--- logic/rsm_droop_filter.sv
// supply droop comparator sync, hysteresis and glitch filter
// assumes two asynchronous comparator levels, high while above threshold
`timescale 1ns/100ps
`default_nettype none
module rsm_droop_filter (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic above_rise,
	input  wire logic above_fall,
	output logic      droop_act
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic       act;
		logic [7:0] cnt;
	} rsm_filt_t;

	rsm_filt_t r;
	rsm_filt_t next_r;
	logic      raw;

	always_comb begin
		next_r = r;
		next_r.s1 = {above_rise, above_fall};
		next_r.s2 = r.s1;
		raw = r.act ? !r.s2[1] : !r.s2[0];
		if (raw == r.act)
			next_r.cnt = 8'h00;
		else if (r.cnt == 8'(rsm_pkg::GLITCH_CYC - 1)) begin
			next_r.act = raw;
			next_r.cnt = 8'h00;
		end else
			next_r.cnt = r.cnt + 8'h01;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			r <= '{s1: 2'h0, s2: 2'h0, act: 1'b1, cnt: 8'h00};
		else
			r <= next_r;
	end

	assign droop_act = r.act;
endmodule
`default_nettype wire

//--- tb/rsm_board.sv
// board side of the reset pin
// assumes the device only pulls the pin low
`timescale 1ns/100ps
`default_nettype none
module rsm_board (
	input  wire logic pull_low,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin
);
	// weak pull-up, external switch to ground
	assign pin = !(pull_low || (pin_oe && !pin_out));
endmodule
`default_nettype wire

//--- tb/rsm_top_tb_top.sv
// bench for rsm_top: pin, vector fetch, cause flags
// assumes rsm_board on the reset pin
`timescale 1ns/100ps
`default_nettype none
module rsm_top_tb_top;
	localparam int DR = rsm_pkg::DROOP_BIT;
	localparam int DG = rsm_pkg::DOG_BIT;
	logic        clk = 1'h0, resetn = 1'h0, rd = 1'h0, wr = 1'h0, wdg = 1'h0;
	logic        ar = 1'h1, af = 1'h1, ext = 1'h0;
	logic        pin, po, poe, crn, vr, pl, wq, ce, osc, drv;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, rdat, q;
	logic [15:0] va, pcv;
	logic [1:0]  dl;
	logic [2:0]  cs;
	int          fails = 0, checked = 0;
	assign drv = poe === 1'h1 && po === 1'h0;
	initial begin
		forever #20 clk = ~clk;
	end
	rsm_top u_rsm_top (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
		.avs_waitrequest(wq), .rst_pin_in(pin), .rst_pin_out(po), .rst_pin_oe(poe),
		.above_rise(ar), .above_fall(af), .wdg_underflow(wdg), .safe_osc_active(1'h0),
		.droop_level_opt(2'h2), .clk_src_opt(3'h5), .supervisor_opt(1'h1),
		.droop_level(dl), .clock_source_selector(cs), .clock_supervisor_en(ce),
		.osc_keep_run(osc), .core_reset_n(crn), .vec_rd(vr), .vec_addr(va),
		.vec_data(va === rsm_pkg::VEC_HI ? 8'hA5 : 8'h3C), .pc(pcv), .pc_load(pl));
	rsm_board u_rsm_board (.pull_low(ext), .pin_out(po), .pin_oe(poe), .pin(pin));
	task conclude;
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic c);
		checked++;
		if (c !== 1'h1) begin
			fails++;
			$display("[FAIL] %0t mismatch", $time);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (wq === 1'h0)
				break;
		end
		q = rdat;
		rd <= 1'h0;
		wr <= 1'h0;
		if (i == 64) begin
			chk(1'h0);
			conclude;
		end
	endtask
	task rdc;
		bus(1'h0, rsm_pkg::CAUSE_OFS, 32'h0);
	endtask
	task boot;
		int i, n, h;
		n = 0;
		h = 0;
		for (i = 0; i < 9000 && pl !== 1'h1; i++) begin
			@(negedge clk);
			n += (vr === 1'h1);
			h += (pin === 1'h1);
		end
		if (i == 9000) begin
			chk(1'h0);
			conclude;
		end
		chk(pcv === 16'hA53C);
		chk(n == 2);
		chk(h >= rsm_pkg::STAB_CYC && h <= rsm_pkg::STAB_CYC + 4);
	endtask
	task t_dog;
		int i;
		@(posedge clk);
		wdg <= 1'h1;
		@(posedge clk);
		wdg <= 1'h0;
		@(negedge clk);
		for (i = 0; drv && i < 9000; i++)
			@(negedge clk);
		chk(i >= rsm_pkg::OUT_CYC);
		boot;
		rdc;
		chk(q[DG] === 1'h1);
	endtask
	task t_droop;
		@(posedge clk);
		af <= 1'h0;
		repeat (2) @(posedge clk);
		af <= 1'h1;
		repeat (20) @(negedge clk);
		chk(crn === 1'h1 && pin === 1'h1);
		@(posedge clk);
		af <= 1'h0;
		ar <= 1'h0;
		repeat (600) @(negedge clk);
		chk(drv && crn === 1'h0);
		@(posedge clk);
		af <= 1'h1;
		repeat (600) @(negedge clk);
		chk(drv);
		@(posedge clk);
		ar <= 1'h1;
		boot;
		rdc;
		chk(q[DR] === 1'h1 && q[DG] === 1'h0);
	endtask
	task t_ext;
		@(posedge clk);
		ext <= 1'h1;
		repeat (20) @(posedge clk);
		ext <= 1'h0;
		@(negedge clk);
		chk(drv && crn === 1'h0);
		boot;
		rdc;
		chk(q[DR] === 1'h1);
		bus(1'h1, rsm_pkg::CAUSE_OFS, 32'h4);
		rdc;
		chk(q[DR] === 1'h0 && q[DG] === 1'h0 && q[rsm_pkg::CSSIE_BIT] === 1'h1);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'h1;
		boot;
		chk(dl === 2'h2 && cs === 3'h5 && ce === 1'h1 && osc === 1'h1);
		bus(1'h0, 4'hC, 32'h0);
		chk(q === 32'h0);
		bus(1'h0, rsm_pkg::STATUS_OFS, 32'h0);
		chk(q === {27'h0, rsm_pkg::S_RUN});
		t_dog;
		t_droop;
		t_ext;
		conclude;
	end
endmodule
`default_nettype wire
